//--- rtl/smon_pkg.sv
/*
  Shared constants and types for the supply monitor status block:
  register indices, status bit positions, thresholds, LED timing and
  controller cycle limits. Assumes a single 200 MHz clock in both ends.
*/
package smon_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 200_000_000;

  // Register indices, also the byte offsets in the controller object
  localparam logic [2:0] REG_STATUS_IDX = 3'h0;
  localparam logic [2:0] REG_AMPS_IDX = 3'h2;
  localparam logic [2:0] REG_VOLTS_IDX = 3'h4;
  localparam int unsigned REG_COUNT = 3;

  // Status bit positions and reset values
  localparam int unsigned LINK_WARN_BIT = 0;
  localparam int unsigned IO_LOW_BIT = 2;
  localparam logic [15:0] READ_RESET = 16'h0000;

  // Function model codes
  localparam logic MODEL_STD = 1'b0;
  localparam logic MODEL_BC = 1'b1;
  localparam logic [15:0] STD_MAX = 16'h00ff;

  // Thresholds in reading units: 0.1 A and 0.1 V per count
  localparam logic [15:0] AMPS_LIMIT_DA = 16'h0017;   // 2.3 A
  localparam logic [15:0] LINK_MIN_DV = 16'h002f;     // 4.7 V
  localparam logic [15:0] IO_MIN_DV = 16'h00cc;       // 20.4 V

  // LED pattern timing: one tick, frame of ticks, flash windows
  localparam int unsigned LED_TICK_MS = 50;
  localparam int unsigned LED_TICK_CYC = LED_TICK_MS * (CLK_HZ / 1000);
  localparam logic [4:0] FRAME_TICKS = 5'h18;
  localparam logic [4:0] FLASH1_END = 5'h04;
  localparam logic [4:0] FLASH2_BEG = 5'h08;
  localparam logic [4:0] FLASH2_END = 5'h0c;
  localparam int unsigned BLINK_BIT = 2;

  // Controller bus cycle limits
  localparam int unsigned MIN_CYCLE_US = 100;
  localparam int unsigned MIN_CYCLE_CYC = MIN_CYCLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MIN_UPDATE_MS = 2;
  localparam int unsigned MIN_UPDATE_CYC = MIN_UPDATE_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 20;
  localparam int unsigned SLOT_COUNT = 1;

  typedef enum logic [1:0] {
    MODE_RESET,
    PRE_RUN_STATE,
    MODE_RUN
  } smon_mode_t;
endpackage

//--- rtl/smon_if.sv
/*
  Register read link between the status device and the bus controller.
  Assumes both ends share clk; the interface carries no clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface smon_if;
  logic model_sel;
  logic rd_strobe;
  logic [2:0] rd_index;
  logic rd_ack;
  logic rd_err;
  logic [15:0] rd_data;

  modport dev (
    input model_sel,
    input rd_strobe,
    input rd_index,
    output rd_ack,
    output rd_err,
    output rd_data
  );

  modport ctl (
    output model_sel,
    output rd_strobe,
    output rd_index,
    input rd_ack,
    input rd_err,
    input rd_data
  );
endinterface
`default_nettype wire

//--- rtl/smon_dev.sv
/*
  Device end: supply status flags, readings, read-only register bank in
  two function models, and the four diagnostic LEDs.
  Assumes readings arrive already digitised in 0.1 A / 0.1 V counts,
  synchronous to clk, and that the controller polls via smon_if.
*/
// Summary of operation
// - Error LED double-flashes on any supply fault
// - Error LED dark when fault-free or unpowered
// - Link LED steady on during link traffic while powered
// - Overload LED on only while link overloaded
// - Bit 0: >2.3 A or <4.7 V
// - Bit 2 set while I/O under 20.4 V
// - Current reading counts 0.1 A each
// - Voltage reading counts 0.1 V each
// - Standard model: 8-bit registers at 0, 2, 4
// - Bus controller model: 16-bit registers, same offsets
// - Offsets place register bytes in controller object
// - Controller maps module into one analog slot
// - Controller bus cycle never below 100 us
// - Fresh data each cycle needs 2 ms cycle
`timescale 1ns/1ps
`default_nettype none
module smon_dev #(
  parameter int unsigned TICK_CYC = smon_pkg::LED_TICK_CYC
) (
  input wire logic clk,
  input wire logic reset,
  smon_if.dev bus,
  input wire logic module_powered,
  input wire smon_pkg::smon_mode_t op_mode,
  input wire logic link_active,
  input wire logic [15:0] feed_amps_in,
  input wire logic [15:0] feed_volts_in,
  input wire logic [15:0] io_volts_in,
  output logic led_mode_green,
  output logic led_error_red,
  output logic led_link_orange,
  output logic led_overload_red
);
  localparam int unsigned TICK_W = $clog2(TICK_CYC + 1);

  logic link_feed_warning_flag_q;
  logic io_feed_low_flag_q;
  logic link_volts_low_q;
  logic overload_q;
  logic [15:0] link_feed_amps_reading_q;
  logic [15:0] link_feed_volts_reading_q;
  logic [15:0] rd_data_q;
  logic rd_ack_q;
  logic rd_err_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic [4:0] frame_q;
  logic led_mode_q;
  logic led_error_q;
  logic led_link_q;
  logic led_overload_q;
  logic [15:0] status_word;
  logic [15:0] sel_data;
  logic sel_hit;
  logic fault;
  logic single_on;
  logic double_on;
  logic blink_on;

  // Clip a reading into the 8-bit standard model range
  function automatic logic [15:0] fit_model(input logic model, input logic [15:0] v);
    logic [15:0] r;
    r = v;
    if (model == smon_pkg::MODEL_STD && v > smon_pkg::STD_MAX) begin
      r = smon_pkg::STD_MAX;
    end
    return r;
  endfunction

  // Threshold comparisons, registered so every flag is glitch free
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_feed_warning_flag_q <= 1'b0;
      io_feed_low_flag_q <= 1'b0;
      link_volts_low_q <= 1'b0;
      overload_q <= 1'b0;
    end else begin
      link_feed_warning_flag_q <= (feed_amps_in > smon_pkg::AMPS_LIMIT_DA) ||
                                  (feed_volts_in < smon_pkg::LINK_MIN_DV);
      io_feed_low_flag_q <= io_volts_in < smon_pkg::IO_MIN_DV;
      link_volts_low_q <= feed_volts_in < smon_pkg::LINK_MIN_DV;
      overload_q <= feed_amps_in > smon_pkg::AMPS_LIMIT_DA;
    end
  end

  // Readings pass through unscaled: one count is one unit of 0.1
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_feed_amps_reading_q <= smon_pkg::READ_RESET;
      link_feed_volts_reading_q <= smon_pkg::READ_RESET;
    end else begin
      link_feed_amps_reading_q <= feed_amps_in;
      link_feed_volts_reading_q <= feed_volts_in;
    end
  end

  // Status word: only bits 0 and 2 carry flags
  always_comb begin
    status_word = 16'h0000;
    status_word[smon_pkg::LINK_WARN_BIT] = link_feed_warning_flag_q;
    status_word[smon_pkg::IO_LOW_BIT] = io_feed_low_flag_q;
  end

  // Register decode; the offset is the byte position in the object
  always_comb begin
    sel_data = 16'h0000;
    sel_hit = 1'b1;
    unique case (bus.rd_index)
      smon_pkg::REG_STATUS_IDX: begin
        sel_data = status_word;
      end
      smon_pkg::REG_AMPS_IDX: begin
        sel_data = fit_model(bus.model_sel, link_feed_amps_reading_q);
      end
      smon_pkg::REG_VOLTS_IDX: begin
        sel_data = fit_model(bus.model_sel, link_feed_volts_reading_q);
      end
      default: begin
        sel_hit = 1'b0;
      end
    endcase
  end

  // Read port: answer one cycle after the strobe, read-only bank
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data_q <= smon_pkg::READ_RESET;
      rd_ack_q <= 1'b0;
      rd_err_q <= 1'b0;
    end else begin
      rd_ack_q <= bus.rd_strobe;
      rd_err_q <= bus.rd_strobe && !sel_hit;
      if (bus.rd_strobe) begin
        rd_data_q <= sel_data;
      end
    end
  end

  assign bus.rd_data = rd_data_q;
  assign bus.rd_ack = rd_ack_q;
  assign bus.rd_err = rd_err_q;

  // LED tick divider; a long tick keeps flashes visible to the eye
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_W'(TICK_CYC - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // Pattern frame shared by all flashing LEDs, so they stay in phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_q <= 5'h00;
    end else if (tick_q) begin
      if (frame_q == smon_pkg::FRAME_TICKS - 5'h01) begin
        frame_q <= 5'h00;
      end else begin
        frame_q <= frame_q + 5'h01;
      end
    end
  end

  // Pattern shapes decoded from the frame position
  assign single_on = frame_q < smon_pkg::FLASH1_END;
  assign double_on = single_on ||
                     (frame_q >= smon_pkg::FLASH2_BEG && frame_q < smon_pkg::FLASH2_END);
  assign blink_on = frame_q[smon_pkg::BLINK_BIT];
  assign fault = overload_q || io_feed_low_flag_q || link_volts_low_q;

  // Green mode LED
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      led_mode_q <= 1'b0;
    end else if (!module_powered) begin
      led_mode_q <= 1'b0;
    end else begin
      unique case (op_mode)
        smon_pkg::MODE_RESET: begin
          led_mode_q <= single_on;
        end
        smon_pkg::PRE_RUN_STATE: begin
          led_mode_q <= blink_on;
        end
        smon_pkg::MODE_RUN: begin
          led_mode_q <= 1'b1;
        end
        default: begin
          led_mode_q <= 1'b0;
        end
      endcase
    end
  end

  // Red error LED, dark unless powered and faulted
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      led_error_q <= 1'b0;
    end else if (module_powered && fault) begin
      led_error_q <= double_on;
    end else begin
      led_error_q <= 1'b0;
    end
  end

  // Orange link LED and red overload LED are steady levels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      led_link_q <= 1'b0;
      led_overload_q <= 1'b0;
    end else begin
      led_link_q <= module_powered && link_active;
      led_overload_q <= module_powered && overload_q;
    end
  end

  assign led_mode_green = led_mode_q;
  assign led_error_red = led_error_q;
  assign led_link_orange = led_link_q;
  assign led_overload_red = led_overload_q;
endmodule
`default_nettype wire

//--- rtl/smon_ctl.sv
/*
  Controller end: polls the three status registers once per accepted
  bus cycle and presents them as one analog slot image.
  Assumes cycle_start pulses come from the user's cycle timer on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module smon_ctl #(
  parameter int unsigned MIN_CYCLE = smon_pkg::MIN_CYCLE_CYC,
  parameter int unsigned MIN_UPDATE = smon_pkg::MIN_UPDATE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  smon_if.ctl bus,
  input wire logic model_in,
  input wire logic cycle_start,
  output logic [15:0] status_out,
  output logic [15:0] amps_out,
  output logic [15:0] volts_out,
  output logic image_valid,
  output logic cycle_refused,
  output logic fresh_ok,
  output logic read_error
);
  typedef enum logic [1:0] {
    C_IDLE,
    C_ISSUE,
    C_WAIT
  } smon_cstate_t;

  localparam logic [smon_pkg::CNT_W-1:0] GAP_MAX = '1;

  smon_cstate_t state_q;
  logic [1:0] slot_q;
  logic [smon_pkg::CNT_W-1:0] gap_q;
  logic model_q;
  logic [15:0] image_q [smon_pkg::REG_COUNT];
  logic valid_q;
  logic refused_q;
  logic fresh_q;
  logic err_q;
  logic accept;

  // Short cycles are refused, not queued
  assign accept = cycle_start && state_q == C_IDLE &&
                  gap_q >= smon_pkg::CNT_W'(MIN_CYCLE);

  // Cycles since the last accepted start, saturating
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_q <= GAP_MAX;
    end else if (accept) begin
      gap_q <= '0;
    end else if (gap_q != GAP_MAX) begin
      gap_q <= gap_q + 1'b1;
    end
  end

  // Poll sequencer over the three registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= C_IDLE;
      slot_q <= 2'h0;
      model_q <= smon_pkg::MODEL_STD;
    end else begin
      unique case (state_q)
        C_IDLE: begin
          if (accept) begin
            state_q <= C_ISSUE;
            slot_q <= 2'h0;
            model_q <= model_in;
          end
        end
        C_ISSUE: begin
          state_q <= C_WAIT;
        end
        C_WAIT: begin
          if (bus.rd_ack) begin
            if (slot_q == 2'(smon_pkg::REG_COUNT - 1)) begin
              state_q <= C_IDLE;
            end else begin
              slot_q <= slot_q + 2'h1;
              state_q <= C_ISSUE;
            end
          end
        end
      endcase
    end
  end

  // Offset is twice the slot: byte position in the object
  assign bus.rd_strobe = state_q == C_ISSUE;
  assign bus.rd_index = {slot_q, 1'b0};
  assign bus.model_sel = model_q;

  // One image of three words forms the single analog slot
  for (genvar g = 0; g < smon_pkg::REG_COUNT; g++) begin : g_img
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        image_q[g] <= smon_pkg::READ_RESET;
      end else if (state_q == C_WAIT && bus.rd_ack && slot_q == 2'(g)) begin
        image_q[g] <= bus.rd_data;
      end
    end
  end

  // End-of-cycle flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      valid_q <= 1'b0;
      refused_q <= 1'b0;
      fresh_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      valid_q <= state_q == C_WAIT && bus.rd_ack &&
                 slot_q == 2'(smon_pkg::REG_COUNT - 1);
      refused_q <= cycle_start && !accept;
      if (accept) begin
        fresh_q <= gap_q >= smon_pkg::CNT_W'(MIN_UPDATE);
        err_q <= 1'b0;
      end else if (state_q == C_WAIT && bus.rd_ack && bus.rd_err) begin
        err_q <= 1'b1;
      end
    end
  end

  assign status_out = image_q[0];
  assign amps_out = image_q[1];
  assign volts_out = image_q[2];
  assign image_valid = valid_q;
  assign cycle_refused = refused_q;
  assign fresh_ok = fresh_q;
  assign read_error = err_q;
endmodule
`default_nettype wire

//--- testbench/smon_chk_sva.sv
/*
  Checker on the read link between the device end and the controller end.
  Assumes one clock shared by both ends and an async high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module smon_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic model_sel,
  input wire logic rd_strobe,
  input wire logic [2:0] rd_index,
  input wire logic rd_ack,
  input wire logic rd_err,
  input wire logic [15:0] rd_data
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Only offsets 0, 2 and 4 hold registers
  logic mapped;
  assign mapped = (rd_index == 3'h0) || (rd_index == 3'h2) || (rd_index == 3'h4);

  // Every read is answered exactly one cycle later, never unasked
  AST_ACK_ONE: assert property (rd_strobe |=> rd_ack)
    else $error("read not answered in one cycle");
  AST_ACK_ASKED: assert property (rd_ack |-> $past(rd_strobe))
    else $error("answer without a request");
  AST_MAPPED_OK: assert property (rd_strobe && mapped |=> !rd_err)
    else $error("mapped offset refused");
  // Every answer flags exactly the unmapped offsets, and those read zero
  AST_UNMAPPED: assert property (rd_ack |-> (rd_err == !$past(mapped)) && (!rd_err || rd_data == 16'h0000))
    else $error("unmapped offset not refused");
  // Byte model never shows upper bits
  AST_STD_BYTE: assert property (rd_strobe && model_sel == smon_pkg::MODEL_STD
    |=> rd_data[15:8] == 8'h00)
    else $error("byte model read has upper bits");
  AST_RESERVED: assert property (rd_strobe && rd_index == 3'h0
    |=> rd_data[15:3] == 13'h0000 && !rd_data[1])
    else $error("reserved status bit set");
  // Data stands until the next answer, so the image can be picked up late
  AST_DATA_HOLD: assert property (!rd_ack |=> rd_ack || $stable(rd_data))
    else $error("read data moved without an answer");
  // One poll walks the object in offset order, a strobe every second cycle
  AST_POLL_ORDER: assert property (rd_strobe && rd_index == 3'h0
    |-> ##2 (rd_strobe && rd_index == 3'h2) ##2 (rd_strobe && rd_index == 3'h4))
    else $error("poll order broken");
  AST_MODEL_HOLD: assert property (rd_strobe && rd_index == 3'h0
    |=> $stable(model_sel) [*6])
    else $error("model changed inside a poll");

  cover property (rd_strobe && model_sel == smon_pkg::MODEL_BC);
  cover property (rd_strobe && rd_index == 3'h4 && model_sel == smon_pkg::MODEL_STD);
  cover property (rd_strobe && rd_index == 3'h0 ##1 rd_data[2]);
endmodule
`default_nettype wire

//--- testbench/supply_monitor_status_tb.sv
/*
  Testbench: controller end polls the device end; bench drives supplies,
  modes and cycle starts at the falling edge and checks images and LEDs.
  Assumes the shortened tick and cycle counts set below.
*/
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_status_tb;
  localparam int TK = 4;
  localparam int FR = 24 * TK;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic pw = 1'b0;
  logic lk = 1'b0;
  logic mdl = 1'b0;
  logic cs = 1'b0;
  smon_pkg::smon_mode_t md = smon_pkg::MODE_RESET;
  logic [15:0] amps = 16'h0000;
  logic [15:0] volts = 16'h0000;
  logic [15:0] io = 16'h0000;
  logic g, e, o, ov, iv, cr, fr_ok, rerr;
  logic [15:0] st, am, vo;
  int err_total = 0;
  int check_count = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  smon_if bus_if();
  smon_dev #(.TICK_CYC(TK)) smon_dev_i (.clk(clk), .reset(reset), .bus(bus_if),
    .module_powered(pw), .op_mode(md), .link_active(lk), .feed_amps_in(amps),
    .feed_volts_in(volts), .io_volts_in(io), .led_mode_green(g), .led_error_red(e),
    .led_link_orange(o), .led_overload_red(ov));
  smon_ctl #(.MIN_CYCLE(20), .MIN_UPDATE(100)) smon_ctl_i (.clk(clk), .reset(reset),
    .bus(bus_if), .model_in(mdl), .cycle_start(cs), .status_out(st), .amps_out(am),
    .volts_out(vo), .image_valid(iv), .cycle_refused(cr), .fresh_ok(fr_ok),
    .read_error(rerr));
  smon_chk smon_chk_i (.clk(clk), .reset(reset), .model_sel(bus_if.model_sel),
    .rd_strobe(bus_if.rd_strobe), .rd_index(bus_if.rd_index), .rd_ack(bus_if.rd_ack),
    .rd_err(bus_if.rd_err), .rd_data(bus_if.rd_data));

  task automatic close_out();
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One accepted controller cycle, then the image against the thresholds
  task automatic run(input logic m, input logic [15:0] a, input logic [15:0] v,
                     input logic [15:0] i, input int gap, input logic fr);
    logic [15:0] xs, lim;
    int n;
    @(negedge clk);
    mdl = m;
    amps = a;
    volts = v;
    io = i;
    repeat (gap) @(negedge clk);
    cs = 1'b1;
    @(negedge clk);
    cs = 1'b0;
    n = 0;
    while (iv !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, iv}, 16'h0001);
    // Strict compares: 2.3 A, 4.7 V, 20.4 V in tenths
    xs = {13'h0000, i < 16'h00cc, 1'b0, (a > 16'h0017) || (v < 16'h002f)};
    lim = (m == smon_pkg::MODEL_STD) ? 16'h00ff : 16'hffff;
    chk(st, xs);
    chk(am, (a > lim) ? lim : a);
    chk(vo, (v > lim) ? lim : v);
    chk({15'h0000, fr_ok}, {15'h0000, fr});
    chk({15'h0000, rerr}, 16'h0000);
  endtask

  // Lit cycles over one whole frame are phase independent
  task automatic leds(input logic p, input smon_pkg::smon_mode_t mm, input logic l,
                      input logic [15:0] a, input logic [15:0] v, input logic [15:0] i,
                      input int xg, input int xe, input int xo, input int xv);
    int cg = 0;
    int ce = 0;
    int co = 0;
    int cv = 0;
    @(negedge clk);
    pw = p;
    md = mm;
    lk = l;
    amps = a;
    volts = v;
    io = i;
    repeat (4) @(negedge clk);
    repeat (FR) begin
      @(negedge clk);
      cg += int'(g === 1'b1);
      ce += int'(e === 1'b1);
      co += int'(o === 1'b1);
      cv += int'(ov === 1'b1);
    end
    chk(16'(cg), 16'(xg));
    chk(16'(ce), 16'(xe));
    chk(16'(co), 16'(xo));
    chk(16'(cv), 16'(xv));
  endtask

  // Main sequence
  initial begin
    int n;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    pw = 1'b1;
    run(smon_pkg::MODEL_STD, 16'h0017, 16'h002f, 16'h00cc, 100, 1'b1);
    run(smon_pkg::MODEL_STD, 16'h0018, 16'h002f, 16'h00cc, 100, 1'b1);
    run(smon_pkg::MODEL_STD, 16'h0017, 16'h002e, 16'h00cc, 100, 1'b1);
    run(smon_pkg::MODEL_STD, 16'h0017, 16'h002f, 16'h00cb, 100, 1'b1);
    run(smon_pkg::MODEL_STD, 16'h012c, 16'h0258, 16'h0064, 100, 1'b1);
    run(smon_pkg::MODEL_BC, 16'h012c, 16'h0258, 16'h00fa, 100, 1'b1);
    run(smon_pkg::MODEL_BC, 16'h1234, 16'h0032, 16'h00f0, 40, 1'b0);
    // Start too soon after the last accepted one
    @(negedge clk);
    cs = 1'b1;
    @(negedge clk);
    cs = 1'b0;
    n = 0;
    while (cr !== 1'b1 && n < 3) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, cr}, 16'h0001);
    leds(1'b1, smon_pkg::MODE_RUN, 1'b1, 16'h0018, 16'h0032, 16'h00f0,
         FR, 8 * TK, FR, FR);
    leds(1'b1, smon_pkg::PRE_RUN_STATE, 1'b0, 16'h000a, 16'h0032, 16'h00f0,
         12 * TK, 0, 0, 0);
    leds(1'b1, smon_pkg::MODE_RESET, 1'b0, 16'h000a, 16'h0032, 16'h00cb,
         4 * TK, 8 * TK, 0, 0);
    leds(1'b1, smon_pkg::MODE_RUN, 1'b1, 16'h000a, 16'h002e, 16'h00f0,
         FR, 8 * TK, FR, 0);
    leds(1'b0, smon_pkg::MODE_RUN, 1'b1, 16'h001e, 16'h002e, 16'h0064,
         0, 0, 0, 0);
    close_out();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
